/* File: rtl/wwdt_cfg.svh */
// Register offsets, field positions, reset values and timing constants for the watchdog.
`ifndef WWDT_CFG_SVH
`define WWDT_CFG_SVH
`define WWDT_ADDR_W 4
`define WWDT_OFF_RST_CTRL 4'h0
`define WWDT_OFF_CFG 4'h1
`define WWDT_OFF_IRQ_STAT 4'h2
`define WWDT_OFF_IRQ_MASK 4'h3
`define WWDT_OFF_COUNT 4'h4
`define WWDT_BIT_IDLE 2
`define WWDT_BIT_SLEEP 3
`define WWDT_BIT_TIMEOUT 4
`define WWDT_BIT_SOFT_EN 5
`define WWDT_CFG_POST_LSB 0
`define WWDT_CFG_PRE_BIT 4
`define WWDT_CFG_WINDOW_DISABLE_BIT 6
`define WWDT_CFG_FORCE_BIT 7
`define WWDT_CFG_WIN_LSB 8
`define WWDT_CFG_RESET 10'h0FF
`define WWDT_IRQ_TIMEOUT 0
`define WWDT_IRQ_WAKE 1
`define WWDT_IRQ_EARLY 2
`define WWDT_PRE_SMALL 7'h1F
`define WWDT_PRE_LARGE 7'h7F
`define WWDT_POST_W 15
`define WWDT_RC_OSC_HZ 32000
`define WWDT_CLK_HZ 25000000
`define WWDT_RST_PULSE_NS 200
`endif

/* File: rtl/wwdt_pkg.sv */
// Types shared by the watchdog files.
package wwdt_pkg;
  typedef struct packed {
    logic [1:0] window_size_select;
    logic watchdog_force_enable;
    logic window_disable;
    logic unused_5;
    logic prescale_select;
    logic [3:0] postscale_select;
  } wwdt_cfg_t;
  typedef struct packed {
    logic clear_watchdog_instr;
    logic power_save_instr;
    logic power_save_idle;
    logic wake_done;
    logic switch_done;
  } wwdt_core_t;
  typedef enum logic [1:0] {
    WWDT_RUN = 2'b00,
    WWDT_SLEEP = 2'b01,
    WWDT_IDLE = 2'b10
  } wwdt_mode_t;
endpackage

/* File: rtl/wwdt_tick.sv */
// Turns the fast clock into single-cycle ticks at the low-power RC rate.
`timescale 1ns/1ps
`include "wwdt_cfg.svh"
module wwdt_tick #(
  parameter int CLK_HZ = `WWDT_CLK_HZ,
  parameter int OSC_HZ = `WWDT_RC_OSC_HZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Control
  input wire logic osc_on,
  output logic tick
);
  // Fractional accumulator keeps the mean rate exact.
  logic [31:0] acc_r;
  logic [31:0] acc_nxt;
  always_comb begin
    acc_nxt = acc_r + 32'(OSC_HZ);
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_r <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (clk_en) begin
      if (!osc_on) begin
        acc_r <= 32'h0000_0000;
        tick <= 1'b0;
      end else if (acc_nxt >= 32'(CLK_HZ)) begin
        acc_r <= acc_nxt - 32'(CLK_HZ);
        tick <= 1'b1;
      end else begin
        acc_r <= acc_nxt;
        tick <= 1'b0;
      end
    end
  end
endmodule

/* File: rtl/wwdt_top.sv */
// Windowed watchdog timer with scalers, power-save handling and flags.
//
// Functional notes
// - Counter runs only on low-power RC ticks; enabling watchdog turns oscillator on.
// - Prescaler divides the 32 kHz clock by 32 or 128.
// - Postscaler divides prescaler output with sixteen ratios from 1:1 to 1:32768.
// - Any device reset clears counter, prescaler and postscaler.
// - A completed clock switch clears counter and both scalers.
// - Power-save instruction clears counter and both scalers.
// - Leaving sleep or idle clears counter and both scalers.
// - Clear instruction in normal run clears counter and both scalers.
// - Watchdog keeps counting in sleep and idle; timeout wakes the core.
// - Force enable set keeps the watchdog on until a configuration write clears it.
// - With force enable low, watchdog runs only while soft enable is set.
// - Soft enable bit is cleared by every device reset.
// - Timeout flag is sticky until software clears it.
// - Window mode: clears are accepted only inside the selected window.
// - Prescale select one gives divide-by-128, zero gives divide-by-32.
// - Postscale ratio is two to the power of the code.
// - Window codes 11,10,01,00 give 25, 37.5, 50, 75 percent.
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "wwdt_cfg.svh"
module wwdt_top #(
  parameter int CLK_HZ = `WWDT_CLK_HZ,
  parameter int OSC_HZ = `WWDT_RC_OSC_HZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Register port
  input wire logic [`WWDT_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Core events
  input wire wwdt_pkg::wwdt_core_t core_evt,
  // Outputs
  output logic low_power_rc_osc_en,
  output logic core_wake,
  output logic device_reset_req,
  output logic irq
);
  localparam int RST_CYC = (`WWDT_RST_PULSE_NS * (CLK_HZ / 1000000)
    + 999) / 1000;
  localparam logic [3:0] RST_CYC_W = 4'(RST_CYC < 1 ? 1 : RST_CYC);

  //////////////////////////////////////////////////////////////////////////
  wwdt_pkg::wwdt_cfg_t cfg_r;
  wwdt_pkg::wwdt_mode_t mode_r;
  logic soft_en_r;
  logic timeout_flag_r;
  logic sleep_flag_r;
  logic idle_flag_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_mask_r;
  logic [6:0] pre_r;
  logic [`WWDT_POST_W-1:0] post_r;
  logic [3:0] rst_cnt_r;
  logic wd_on;
  logic tick;
  logic pre_done;
  logic post_done;
  logic scaler_clr;
  logic clr_ok;
  logic early_clr;
  logic timeout;
  logic wr_rst_ctrl;
  logic wr_stat;

  // Final postscaler count for a code: 2^code - 1.
  function automatic logic [`WWDT_POST_W-1:0] post_last(
    input logic [3:0] code);
    post_last = `WWDT_POST_W'((16'h0001 << code) - 16'h0001);
  endfunction

  // Clear window opens once this many postscaler counts have passed.
  function automatic logic [`WWDT_POST_W-1:0] win_open(
    input logic [3:0] code, input logic [1:0] win);
    logic [`WWDT_POST_W+2:0] p;
    p = (`WWDT_POST_W+3)'(16'h0001 << code);
    case (win)
      2'b11: win_open = `WWDT_POST_W'((p * 3) >> 2);
      2'b10: win_open = `WWDT_POST_W'((p * 5) >> 3);
      2'b01: win_open = `WWDT_POST_W'(p >> 1);
      default: win_open = `WWDT_POST_W'(p >> 2);
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  assign wd_on = cfg_r.watchdog_force_enable | soft_en_r;
  assign low_power_rc_osc_en = wd_on;
  assign wr_rst_ctrl = reg_wr && reg_addr == `WWDT_OFF_RST_CTRL;
  assign wr_stat = reg_wr && reg_addr == `WWDT_OFF_IRQ_STAT;

  wwdt_tick #(
    .CLK_HZ(CLK_HZ),
    .OSC_HZ(OSC_HZ)
  ) u_tick (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .osc_on(wd_on),
    .tick(tick)
  );

  // Prescaler terminal count; the counter only steps on RC ticks.
  assign pre_done = tick && pre_r == (cfg_r.prescale_select ?
    `WWDT_PRE_LARGE : `WWDT_PRE_SMALL);
  assign post_done = pre_done &&
    post_r == post_last(cfg_r.postscale_select);
  assign timeout = wd_on && post_done;

  // A clear in window mode before the window opens is refused.
  assign clr_ok = cfg_r.window_disable ||
    post_r >= win_open(cfg_r.postscale_select,
    cfg_r.window_size_select);
  assign early_clr = core_evt.clear_watchdog_instr &&
    mode_r == wwdt_pkg::WWDT_RUN && wd_on && !clr_ok;

  assign scaler_clr = core_evt.switch_done
    || core_evt.power_save_instr
    || (core_evt.wake_done && mode_r != wwdt_pkg::WWDT_RUN)
    || (core_evt.clear_watchdog_instr && mode_r == wwdt_pkg::WWDT_RUN
    && clr_ok)
    || !wd_on;

  //////////////////////////////////////////////////////////////////////////
  // Counter and scalers; device reset clears all of them.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_r <= 7'h00;
      post_r <= `WWDT_POST_W'h0000;
    end else if (clk_en) begin
      if (scaler_clr) begin
        pre_r <= 7'h00;
        post_r <= `WWDT_POST_W'h0000;
      end else if (post_done) begin
        pre_r <= 7'h00;
        post_r <= `WWDT_POST_W'h0000;
      end else if (pre_done) begin
        pre_r <= 7'h00;
        post_r <= post_r + `WWDT_POST_W'h0001;
      end else if (tick) begin
        pre_r <= pre_r + 7'h01;
      end
    end
  end

  // Power mode tracking; timeout in sleep or idle wakes the core.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= wwdt_pkg::WWDT_RUN;
      core_wake <= 1'b0;
    end else if (clk_en) begin
      core_wake <= 1'b0;
      if (core_evt.power_save_instr) begin
        mode_r <= core_evt.power_save_idle ? wwdt_pkg::WWDT_IDLE :
          wwdt_pkg::WWDT_SLEEP;
      end else if (mode_r != wwdt_pkg::WWDT_RUN && timeout) begin
        core_wake <= 1'b1;
        mode_r <= wwdt_pkg::WWDT_RUN;
      end else if (core_evt.wake_done) begin
        mode_r <= wwdt_pkg::WWDT_RUN;
      end
    end
  end

  // Device reset request pulse on a run-mode timeout.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_cnt_r <= 4'h0;
    end else if (clk_en) begin
      if (timeout && mode_r == wwdt_pkg::WWDT_RUN) begin
        rst_cnt_r <= RST_CYC_W;
      end else if (rst_cnt_r != 4'h0) begin
        rst_cnt_r <= rst_cnt_r - 4'h1;
      end
    end
  end
  assign device_reset_req = rst_cnt_r != 4'h0;

  //////////////////////////////////////////////////////////////////////////
  // Status bits of the reset control register; hardware set wins.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      soft_en_r <= 1'b0;
      timeout_flag_r <= 1'b0;
      sleep_flag_r <= 1'b0;
      idle_flag_r <= 1'b0;
    end else if (clk_en) begin
      if (wr_rst_ctrl) begin
        soft_en_r <= reg_wdata[`WWDT_BIT_SOFT_EN];
      end
      if (timeout) begin
        timeout_flag_r <= 1'b1;
      end else if (wr_rst_ctrl) begin
        timeout_flag_r <= reg_wdata[`WWDT_BIT_TIMEOUT];
      end
      if (core_evt.power_save_instr && !core_evt.power_save_idle) begin
        sleep_flag_r <= 1'b1;
      end else if (wr_rst_ctrl) begin
        sleep_flag_r <= reg_wdata[`WWDT_BIT_SLEEP];
      end
      if (core_evt.power_save_instr && core_evt.power_save_idle) begin
        idle_flag_r <= 1'b1;
      end else if (wr_rst_ctrl) begin
        idle_flag_r <= reg_wdata[`WWDT_BIT_IDLE];
      end
    end
  end

  // Configuration word, loaded by software in place of fuse shadows.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_r <= wwdt_pkg::wwdt_cfg_t'(`WWDT_CFG_RESET);
    end else if (clk_en && reg_wr && reg_addr == `WWDT_OFF_CFG) begin
      cfg_r <= wwdt_pkg::wwdt_cfg_t'(reg_wdata[9:0]);
    end
  end

  // Interrupt status, write one to clear; new events win over the clear.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_r <= 3'h0;
      irq_mask_r <= 3'h0;
    end else if (clk_en) begin
      irq_stat_r <= (irq_stat_r & ~(wr_stat ? reg_wdata[2:0] : 3'h0))
        | {early_clr, core_wake, timeout};
      if (reg_wr && reg_addr == `WWDT_OFF_IRQ_MASK) begin
        irq_mask_r <= reg_wdata[2:0];
      end
    end
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  // Read data one cycle after the read strobe; unmapped reads give zero.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      reg_rdata <= 16'h0000;
      if (reg_rd) begin
        case (reg_addr)
          `WWDT_OFF_RST_CTRL: reg_rdata <= 16'({soft_en_r, timeout_flag_r,
            sleep_flag_r, idle_flag_r, 2'b00});
          `WWDT_OFF_CFG: reg_rdata <= 16'(cfg_r);
          `WWDT_OFF_IRQ_STAT: reg_rdata <= 16'(irq_stat_r);
          `WWDT_OFF_IRQ_MASK: reg_rdata <= 16'(irq_mask_r);
          `WWDT_OFF_COUNT: reg_rdata <= 16'(post_r);
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end
endmodule

/* File: dv/wwdt_core_model.sv */
// Processor core model that answers a watchdog wake after a delay.
`timescale 1ns/1ps
module wwdt_core_model #(
  parameter int WAKE_DLY = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Instructions and answer
  input wire wwdt_pkg::wwdt_core_t cmd,
  input wire logic core_wake,
  output wwdt_pkg::wwdt_core_t core_evt
);
  logic [3:0] dly_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dly_r <= '0;
      core_evt <= '0;
    end else begin
      // The wake answer is merged into the command word in one assignment.
      core_evt <= wwdt_pkg::wwdt_core_t'(cmd | {3'b000, dly_r == 4'h1,
        1'b0});
      if (core_wake) dly_r <= 4'(WAKE_DLY);
      else if (dly_r != 4'h0) dly_r <= dly_r - 4'h1;
    end
  end
endmodule

/* File: dv/wwdt_checker.sv */
// Port assertions for the watchdog top level.
`timescale 1ns/1ps
`include "wwdt_cfg.svh"
module wwdt_checker #(
  parameter int CLK_HZ = 25000000,
  parameter int OSC_HZ = 32000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Register port
  input wire logic [`WWDT_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Core side
  input wire wwdt_pkg::wwdt_core_t core_evt,
  input wire logic low_power_rc_osc_en,
  input wire logic core_wake,
  input wire logic device_reset_req,
  input wire logic irq
);
  logic [15:0] cfg_r;
  logic soft_r;
  logic slp_r;
  logic [2:0] msk_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_r <= 16'h00FF;
      soft_r <= 1'b0;
      msk_r <= '0;
    end else if (reg_wr && clk_en) begin
      if (reg_addr == `WWDT_OFF_CFG) cfg_r <= reg_wdata;
      if (reg_addr == `WWDT_OFF_RST_CTRL) soft_r <= reg_wdata[5];
      if (reg_addr == `WWDT_OFF_IRQ_MASK) msk_r <= reg_wdata[2:0];
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) slp_r <= 1'b0;
    else if (core_evt.power_save_instr) slp_r <= 1'b1;
    else if (core_evt.wake_done) slp_r <= 1'b0;
  end
  ////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_rd_cnt;
    reg_rd && reg_addr == `WWDT_OFF_COUNT;
  endsequence
  property p_cleared(logic ev);
    ev ##1 s_rd_cnt |=> reg_rdata == 16'h0000;
  endproperty
  a_osc_enable:
    assert property (low_power_rc_osc_en == (cfg_r[7] | soft_r))
    else $error("oscillator enable mismatch");
  a_rdata_idle: assert property (reg_rdata != 16'h0000 |-> $past(reg_rd))
    else $error("read data outside read slot");
  a_wake_pulse:
    assert property (core_wake |=> !core_wake) else $error("wake too long");
  a_reset_len:
    assert property ($rose(device_reset_req) |->
      device_reset_req [*5] ##1 !device_reset_req)
    else $error("reset request length wrong");
  a_clr_switch:
    assert property (p_cleared(core_evt.switch_done))
    else $error("count kept after switch");
  a_clr_psave:
    assert property (p_cleared(core_evt.power_save_instr))
    else $error("count kept after power save");
  a_clr_wake:
    assert property (p_cleared(core_evt.wake_done))
    else $error("count kept after wake");
  a_clr_instr:
    assert property (p_cleared(core_evt.clear_watchdog_instr && cfg_r[6]
      && !slp_r)) else $error("count kept after clear");
  a_sleep_noreset:
    assert property (slp_r |-> !device_reset_req)
    else $error("reset while asleep");
  a_run_nowake:
    assert property (!slp_r |-> !core_wake) else $error("wake while running");
  a_wake_irq:
    assert property (core_wake && msk_r[1] |-> ##[0:2] irq)
    else $error("wake interrupt missing");
endmodule
bind wwdt_top wwdt_checker #(.CLK_HZ(CLK_HZ), .OSC_HZ(OSC_HZ))
  wwdt_checker_inst (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_evt(core_evt),
  .low_power_rc_osc_en(low_power_rc_osc_en), .core_wake(core_wake),
  .device_reset_req(device_reset_req), .irq(irq));

/* File: dv/tb_windowed_watchdog_timer.sv */
// Self-checking bench for the windowed watchdog.
`timescale 1ns/1ps
`include "wwdt_cfg.svh"
module tb_windowed_watchdog_timer;
  logic clk = 0, reset_n = 0, clk_en = 1, reg_wr = 0, reg_rd = 0;
  logic [3:0] reg_addr = '0;
  logic [15:0] reg_wdata = '0, reg_rdata, d;
  logic osc_en, wake, rreq, irq;
  wwdt_pkg::wwdt_core_t cmd = '0, core_evt;
  int n_errors = 0, check_count = 0, cyc = 0, n, i, k;
  logic [15:0] rows [4][2] = '{'{16'h00C0, 16'd64}, '{16'h00D0, 16'd256},
    '{16'h00C2, 16'd256}, '{16'h00C3, 16'd512}};
  logic [4:0] evs [4] = '{5'h10, 5'h01, 5'h08, 5'h02};
  wwdt_top #(.OSC_HZ(12500000)) wwdt_top_inst (.clk(clk), .reset_n(reset_n),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .core_evt(core_evt), .low_power_rc_osc_en(osc_en), .core_wake(wake),
    .device_reset_req(rreq), .irq(irq));
  wwdt_core_model wwdt_core_model_inst (.clk(clk), .reset_n(reset_n),
    .cmd(cmd), .core_wake(wake), .core_evt(core_evt));
  always #20 clk = ~clk;
  ////////////////////////////////////////
  task automatic chk(string s, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic ev(logic [4:0] e);
    @(posedge clk);
    cmd <= e;
    @(posedge clk);
    cmd <= '0;
  endtask
  task automatic results();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      results();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    rd(`WWDT_OFF_RST_CTRL);
    chk("rst_ctrl", 16'h0000, d);
    rd(`WWDT_OFF_COUNT);
    chk("count", 16'h0000, d);
    rd(4'hF);
    chk("unmapped", 16'h0000, d);
    chk("osc", 16'h0001, {15'h0, osc_en});
    // Each row is a configuration beside its timeout in clocks.
    for (i = 0; i < 4; i++) begin
      wr(`WWDT_OFF_CFG, rows[i][0]);
      ev(5'h10);
      for (n = 0; rreq !== 1'b1 && n < 2000; n++) @(negedge clk);
      k = (n > int'(rows[i][1]) + 4 || n < int'(rows[i][1]) - 4);
      chk("period", rows[i][1], k ? 16'(n) : rows[i][1]);
      rd(`WWDT_OFF_RST_CTRL);
      chk("flag", 16'h0010, d & 16'h0010);
      wr(`WWDT_OFF_RST_CTRL, 16'h0000);
    end
    wr(`WWDT_OFF_CFG, 16'h0043);
    chk("osc_off", 16'h0000, {15'h0, osc_en});
    wr(`WWDT_OFF_RST_CTRL, 16'h0020);
    chk("osc_on", 16'h0001, {15'h0, osc_en});
    for (k = 0; k < 4; k++) begin
      repeat (200) @(posedge clk);
      rd(`WWDT_OFF_COUNT);
      chk("count_run", 16'h0001, {15'h0, d != 16'h0});
      ev(evs[k]);
      rd(`WWDT_OFF_COUNT);
      chk("count_clr", 16'h0000, d);
    end
    wr(`WWDT_OFF_IRQ_MASK, 16'h0006);
    for (k = 0; k < 2; k++) begin
      ev(k ? 5'h0C : 5'h08);
      for (n = 0; wake !== 1'b1 && n < 1200; n++) @(negedge clk);
      chk("wake", 16'h0001, {15'h0, wake & ~rreq});
      rd(`WWDT_OFF_RST_CTRL);
      chk("mode", k ? 16'h0014 : 16'h0018, d & 16'h001C);
      chk("irq", 16'h0001, {15'h0, irq});
      wr(`WWDT_OFF_IRQ_STAT, 16'h0007);
      wr(`WWDT_OFF_RST_CTRL, 16'h0020);
      chk("irq_clr", 16'h0000, {15'h0, irq});
    end
    wr(`WWDT_OFF_CFG, 16'h0303);
    ev(5'h10);
    rd(`WWDT_OFF_COUNT);
    chk("early", 16'h0001, {15'h0, irq});
    repeat (400) @(posedge clk);
    ev(5'h10);
    rd(`WWDT_OFF_COUNT);
    chk("late", 16'h0000, d);
    // With the enable low for 300 cycles the count must not move.
    @(posedge clk);
    clk_en <= 1'b0;
    repeat (300) @(posedge clk);
    clk_en <= 1'b1;
    rd(`WWDT_OFF_COUNT);
    chk("freeze", 16'h0000, d);
    results();
  end
endmodule
